// ==== bench/pcm_board.sv ====
// board model: resolves each pin from the port's drive and the board level
`timescale 1ns/1ps
module pcm_board (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] boardLevel,
  output logic      [7:0] pinIn
);
  // a driven pin shows the port value, an undriven one whatever the board holds
  assign pinIn = (pinOut & pinOe) | (boardLevel & ~pinOe);
endmodule : pcm_board

// ==== bench/pcm_port_c_chk.sv ====
// checker: port drive and register read relations seen at the top ports
`timescale 1ns/1ps
module pcm_port_c_chk
  import pcm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [2:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regRdata,
  input  wire logic [7:0]  pinOut,
  input  wire logic [7:0]  pinOe,
  input  wire pcm_periph_s periph,
  input  wire logic        capcomp2RouteSel,
  input  wire logic        slowOscAnalogEn,
  input  wire logic        usbOn,
  input  wire logic        xcvrExternal
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // the bench leaves one idle cycle between a write and the following read
  property p_latch_rw;
    regWr && regAddr == REG_OUT_LATCH ##1 !regWr ##1 regRd && regAddr == REG_OUT_LATCH
      |=> regRdata == ($past(regWdata, 3) & LATCH_MASK);
  endproperty
  a_latch_rw: assert property (p_latch_rw) else $error("latch readback wrong");
  property p_dir_rw;
    regWr && regAddr == REG_DIRECTION ##1 !regWr ##1 regRd && regAddr == REG_DIRECTION
      |=> regRdata == ($past(regWdata, 3) & 8'hC7);
  endproperty
  a_dir_rw: assert property (p_dir_rw) else $error("direction readback wrong");
  property p_unimpl;
    regRd && (regAddr == REG_DIRECTION || regAddr == REG_OUT_LATCH) |=> (regRdata & 8'h38) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");
  property p_pin3;
    pinOe[3] == 1'b0;
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin 3 driven");
  property p_osc;
    slowOscAnalogEn && $past(slowOscAnalogEn) |-> pinOe[1:0] == 2'b00;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins driven");
  property p_usb45;
    |pinOe[5:4] |-> usbOn && !xcvrExternal;
  endproperty
  a_usb45: assert property (p_usb45) else $error("usb pins driven outside usb");
  property p_xcvr_oe;
    $past(usbOn && xcvrExternal && !periph.osc1En) && usbOn && xcvrExternal && !periph.osc1En
      |-> pinOe[1] && pinOut[1] == $past(periph.xcvrOe);
  endproperty
  a_xcvr_oe: assert property (p_xcvr_oe) else $error("transceiver enable missing");
  property p_route;
    regWr && regAddr == REG_PERIPH_CFG |=> ##1 capcomp2RouteSel == $past(regWdata[0], 2);
  endproperty
  a_route: assert property (p_route) else $error("route select wrong");
  property p_usb_on;
    regWr && regAddr == REG_USB_CONTROL |=> ##1 usbOn == $past(regWdata[3], 2);
  endproperty
  a_usb_on: assert property (p_usb_on) else $error("usb on copy wrong");
endmodule : pcm_port_c_chk

bind pcm_port_c pcm_port_c_chk u_pcm_port_c_chk (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut), .pinOe(pinOe), .periph(periph),
  .capcomp2RouteSel(capcomp2RouteSel), .slowOscAnalogEn(slowOscAnalogEn), .usbOn(usbOn),
  .xcvrExternal(xcvrExternal));

// ==== bench/pcm_port_c_tb_top.sv ====
// testbench: register access, pin drive and peripheral override scenarios
`timescale 1ns/1ps
module pcm_port_c_tb_top
  import pcm_pkg::*;
;
  logic clk_sys, rst, regWr, regRd;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, pinIn, pinOut, pinOe, boardLevel;
  pcm_periph_s periph;
  logic capcomp2RouteSel, slowOscAnalogEn, extCounterIn, capcomp2CaptureIn, capcomp1CaptureIn;
  logic usbDmIn, usbDpIn, xcvrMinusRx, xcvrPlusRx, serRxIn, serClkIn, usbOn, xcvrExternal;
  int errors, checks_done;

  pcm_port_c u_pcm_port_c (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .periph(periph), .capcomp2RouteSel(capcomp2RouteSel),
    .slowOscAnalogEn(slowOscAnalogEn), .extCounterIn(extCounterIn),
    .capcomp2CaptureIn(capcomp2CaptureIn), .capcomp1CaptureIn(capcomp1CaptureIn),
    .usbDmIn(usbDmIn),
    .usbDpIn(usbDpIn), .xcvrMinusRx(xcvrMinusRx), .xcvrPlusRx(xcvrPlusRx),
    .serRxIn(serRxIn), .serClkIn(serClkIn), .usbOn(usbOn), .xcvrExternal(xcvrExternal));
  pcm_board u_pcm_board (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel),
    .pinIn(pinIn));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // watchdog: a stuck sequence ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a; regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rchk
  // pin levels arrive three edges late, so four leaves margin
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    errors = 0; checks_done = 0; rst = 1'b1; regAddr = 3'h0; regWdata = 8'h00;
    regWr = 1'b0; regRd = 1'b0; periph = '0; boardLevel = 8'h00;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(REG_OUT_LATCH, 8'h00); rchk(REG_DIRECTION, 8'hC7);
    rchk(REG_USB_CONTROL, 8'h00); rchk(REG_PERIPH_CFG, 8'h01);
    rchk(3'h5, 8'h00); chk(pinOe, 8'h00);
    wr(REG_OUT_LATCH, 8'hFF); rchk(REG_OUT_LATCH, 8'hC7);
    wr(REG_DIRECTION, 8'h00); wt(2); chk(pinOe, 8'hC7); chk(pinOut & pinOe, 8'hC7);
    wt(4); rchk(REG_PIN_LEVEL, 8'hC7);
    wr(REG_DIRECTION, 8'hFF); rchk(REG_DIRECTION, 8'hC7);
    boardLevel <= 8'h30; wt(4); rchk(REG_PIN_LEVEL, 8'h30); chk(pinOe, 8'h00);
    rchk(REG_OUT_LATCH, 8'hC7); wr(REG_PIN_LEVEL, 8'h00); rchk(REG_OUT_LATCH, 8'h00);
    // oscillator owns pins 0 and 1 while the latch drives pins 2, 6 and 7 low
    @(posedge clk_sys); boardLevel <= 8'hFF; periph.osc1En <= 1'b1;
    wr(REG_DIRECTION, 8'h00); wt(4); chk({7'h00, slowOscAnalogEn}, 8'h01);
    chk(pinOe, 8'hC4); rchk(REG_PIN_LEVEL, 8'h30); rchk(REG_DIRECTION, 8'h00);
    @(posedge clk_sys); periph.osc1En <= 1'b0; periph.capcomp2IsOutput <= 1'b1;
    periph.capcomp2Out <= 1'b1; wt(2); chk(pinOut & pinOe, 8'h02);
    wr(REG_PERIPH_CFG, 8'h00); wt(2); chk(pinOut & pinOe, 8'h00);
    chk({7'h00, capcomp2RouteSel}, 8'h00);
    @(posedge clk_sys); periph.capcomp2IsOutput <= 1'b0; wr(REG_PERIPH_CFG, 8'h01);
    wr(REG_DIRECTION, 8'hFF); boardLevel <= 8'h07; wt(4);
    chk({5'h00, extCounterIn, capcomp1CaptureIn, capcomp2CaptureIn}, 8'h07);
    wr(REG_DIRECTION, 8'h00); periph.pwmAActive <= 1'b1; periph.pwmAOut <= 1'b1;
    wt(2); chk(pinOut & pinOe, 8'h04);
    @(posedge clk_sys); periph.pwmShutdown <= 1'b1; wr(REG_PERIPH_CFG, 8'h05);
    wt(2); chk(pinOe & 8'h04, 8'h00);
    @(posedge clk_sys); periph.pwmAActive <= 1'b0; periph.capcomp1IsOutput <= 1'b1;
    periph.capcomp1Out <= 1'b1; wt(2); chk(pinOut & pinOe, 8'h04);
    @(posedge clk_sys); periph.capcomp1IsOutput <= 1'b0; periph.serMode <= PCM_SER_ASYNC;
    periph.serTxOut <= 1'b1; wt(2); chk(pinOut & pinOe, 8'h40);
    @(posedge clk_sys); periph.serMode <= PCM_SER_SYNC; periph.serClkMaster <= 1'b1;
    periph.serClkOut <= 1'b1; periph.serDataTx <= 1'b1; periph.serDataOut <= 1'b1;
    wr(REG_DIRECTION, 8'hFF); wt(2); chk(pinOut & pinOe, 8'hC0);
    @(posedge clk_sys); periph.serClkMaster <= 1'b0; periph.serDataTx <= 1'b0;
    boardLevel <= 8'hC0; wt(4); chk({6'h00, serRxIn, serClkIn}, 8'h03);
    chk(pinOe & 8'hC0, 8'h00);
    @(posedge clk_sys); periph.serMode <= PCM_SER_OFF; periph.spiActive <= 1'b1;
    periph.spiDataOut <= 1'b1; wr(REG_DIRECTION, 8'h00); wt(2);
    chk(pinOut & pinOe, 8'h80);
    @(posedge clk_sys); periph.spiActive <= 1'b0; wr(REG_DIRECTION, 8'hFF);
    // external transceiver: enable on pin 1, receive lines on pins 4 and 5
    wr(REG_USB_CONTROL, 8'h08); wr(REG_PERIPH_CFG, 8'h03); periph.xcvrOe <= 1'b1;
    boardLevel <= 8'h30; wt(4); chk(pinOe, 8'h02); chk(pinOut & 8'h02, 8'h02);
    chk({6'h00, xcvrPlusRx, xcvrMinusRx}, 8'h03); rchk(REG_PIN_LEVEL, 8'h02);
    chk({6'h00, usbOn, xcvrExternal}, 8'h03);
    wr(REG_PERIPH_CFG, 8'h01); periph.usbDrive <= 1'b1; periph.usbDmOut <= 1'b1;
    wt(2); chk(pinOe & 8'h30, 8'h30); chk(pinOut & 8'h30, 8'h10);
    @(posedge clk_sys); periph.usbDrive <= 1'b0; boardLevel <= 8'h20; wt(4);
    chk({6'h00, usbDpIn, usbDmIn}, 8'h02);
    end_of_test();
  end
endmodule : pcm_port_c_tb_top

// ==== verilog/pcm_pkg.sv ====
// package: register map, reset values and carrier structs of the port C pin mux
package pcm_pkg;

  localparam logic [2:0] REG_PIN_LEVEL   = 3'h0;
  localparam logic [2:0] REG_OUT_LATCH   = 3'h1;
  localparam logic [2:0] REG_DIRECTION   = 3'h2;
  localparam logic [2:0] REG_USB_CONTROL = 3'h3;
  localparam logic [2:0] REG_PERIPH_CFG  = 3'h4;

  localparam logic [7:0] LATCH_MASK   = 8'hC7;
  localparam logic [7:0] PIN_MASK     = 8'hF7;
  localparam logic [7:0] USBCTL_MASK  = 8'h7E;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET    = 8'hC7;
  localparam logic [7:0] USBCTL_RESET = 8'h00;
  localparam logic [7:0] PCFG_RESET   = 8'h01;

  localparam int USBCTL_ON_BIT       = 3;
  localparam int PCFG_CAPCOMP2_ROUTE = 0;
  localparam int PCFG_XCVR_EXT     = 1;
  localparam int PCFG_PWMA_TRISTATE = 2;

  typedef enum logic [1:0] {
    PCM_SER_OFF,
    PCM_SER_ASYNC,
    PCM_SER_SYNC
  } pcm_ser_mode_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcm_bus_req_s;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pcm_pin_drive_s;

  typedef struct packed {
    logic       osc1En;
    logic       capcomp2Out;
    logic       capcomp2IsOutput;
    logic       capcomp1Out;
    logic       capcomp1IsOutput;
    logic       pwmAActive;
    logic       pwmAOut;
    logic       pwmShutdown;
    logic       usbDmOut;
    logic       usbDpOut;
    logic       usbDrive;
    logic       xcvrOe;
    pcm_ser_mode_e serMode;
    logic       serTxOut;
    logic       serClkMaster;
    logic       serClkOut;
    logic       serDataTx;
    logic       serDataOut;
    logic       spiActive;
    logic       spiDataOut;
  } pcm_periph_s;

endpackage : pcm_pkg

// ==== verilog/pcm_port_c.sv ====
// port C pin multiplexer: latch/direction registers and peripheral overrides
//
// Contract
// RULE1: direction 1 makes a pin high-impedance input; 0 drives the latch value.
// RULE2: reading the latch register returns latch contents, not pin levels.
// RULE3: slow oscillator enabled takes pins 0 and 1, digital paths disabled.
// RULE4: pin 1 drives second compare output at direction 0, feeds capture at 1.
// RULE5: second capcomp on pin 1 unless route bit is 0, then other port.
// RULE6: external transceiver output enable driven on pin 1.
// RULE7: pin 2 drives first compare output over port data, capture at 1.
// RULE8: pin 2 carries pwm channel A, optional high-impedance during shutdown.
// RULE9: pins 4 and 5 input only; port input disabled while usb on.
// RULE10: internal transceiver: pins 4 and 5 are usb lines, usb sets direction.
// RULE11: external transceiver: pins 4 and 5 are receive inputs.
// RULE12: async mode: pin 6 drives transmit data over port data.
// RULE13: sync mode: pin 6 drives clock as master, else takes external clock.
// RULE14: pin 7 feeds receive; sync mode drives data when transmitting.
// RULE15: pin 7 carries spi data out when its direction bit is 0.
// RULE16: unimplemented bits of pin, latch and direction registers read 0.
// RULE17: pins 0 and 1 supply external counter input at direction 1. Code feeds extCounterIn from pin 0 only.
// RULE18: direction register reads its stored contents despite overrides.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module pcm_port_c
  import pcm_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [2:0]   regAddr,
  input  wire logic [7:0]   regWdata,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic      [7:0]   regRdata,
  input  wire logic [7:0]   pinIn,
  output logic      [7:0]   pinOut,
  output logic      [7:0]   pinOe,
  input  wire pcm_periph_s  periph,
  output logic              capcomp2RouteSel,
  output logic              slowOscAnalogEn,
  output logic              extCounterIn,
  output logic              capcomp2CaptureIn,
  output logic              capcomp1CaptureIn,
  output logic              usbDmIn,
  output logic              usbDpIn,
  output logic              xcvrMinusRx,
  output logic              xcvrPlusRx,
  output logic              serRxIn,
  output logic              serClkIn,
  output logic              usbOn,
  output logic              xcvrExternal
);

  pcm_bus_req_s   req;
  pcm_pin_drive_s drv;
  logic [7:0]     pinSync;
  logic [7:0]     pinLevel;
  logic [7:0]     latch_r;
  logic [7:0]     dir_r;
  logic [7:0]     usbCtl_r;
  logic [7:0]     pcfg_r;
  logic           usbOnNow;
  logic           extXcvr;
  logic           capcomp2Here;

  assign req.addr  = regAddr;
  assign req.wdata = regWdata;
  assign req.wr    = regWr;
  assign req.rd    = regRd;

  pcm_sync #(.W(8)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  pcm_regs u_regs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .req      (req),
    .pinLevel (pinLevel),
    .latch_r  (latch_r),
    .dir_r    (dir_r),
    .usbCtl_r (usbCtl_r),
    .pcfg_r   (pcfg_r),
    .rdData_r (regRdata)
  );

  assign usbOnNow     = usbCtl_r[USBCTL_ON_BIT];
  assign extXcvr      = pcfg_r[PCFG_XCVR_EXT];
  assign capcomp2Here = pcfg_r[PCFG_CAPCOMP2_ROUTE]; // [RULE5]

  // level seen by software; analog or usb-owned pins read 0
  always_comb begin
    pinLevel = pinSync;
    if (periph.osc1En) begin
      pinLevel[1:0] = 2'h0; // [RULE3]
    end
    if (usbOnNow) begin
      pinLevel[5:4] = 2'h0; // [RULE9]
    end
    pinLevel[3] = 1'b0; // [RULE16]
  end

  // pin drive: peripherals override the latch where they take priority
  always_comb begin
    drv.o  = latch_r;
    drv.oe = ~dir_r & LATCH_MASK; // [RULE1]
    // pin 1: external transceiver enable, else second capcomp output
    if (usbOnNow && extXcvr) begin
      drv.o[1]  = periph.xcvrOe; // [RULE6]
      drv.oe[1] = 1'b1; // [RULE6]
    end else if (capcomp2Here && periph.capcomp2IsOutput && !dir_r[1]) begin
      drv.o[1] = periph.capcomp2Out; // [RULE4]
    end
    // pin 2: pwm channel A, else first capcomp output
    if (periph.pwmAActive) begin
      drv.o[2]  = periph.pwmAOut; // [RULE8]
      drv.oe[2] = !dir_r[2] && !(periph.pwmShutdown && pcfg_r[PCFG_PWMA_TRISTATE]); // [RULE8]
    end else if (periph.capcomp1IsOutput && !dir_r[2]) begin
      drv.o[2] = periph.capcomp1Out; // [RULE7]
    end
    // pins 4/5 only driven by the internal transceiver
    if (usbOnNow && !extXcvr && periph.usbDrive) begin
      drv.o[4]  = periph.usbDmOut; // [RULE10]
      drv.o[5]  = periph.usbDpOut; // [RULE10]
      drv.oe[4] = 1'b1; // [RULE10]
      drv.oe[5] = 1'b1; // [RULE10]
    end
    // pin 6: usart transmit or master clock
    case (periph.serMode)
      PCM_SER_ASYNC: begin
        drv.o[6] = periph.serTxOut; // [RULE12]
      end
      PCM_SER_SYNC: begin
        drv.o[6]  = periph.serClkOut; // [RULE13]
        drv.oe[6] = periph.serClkMaster; // [RULE13]
      end
      default: begin
      end
    endcase
    // pin 7: sync data transmit, else spi data out
    if (periph.serMode == PCM_SER_SYNC) begin
      drv.o[7]  = periph.serDataOut; // [RULE14]
      drv.oe[7] = periph.serDataTx; // [RULE14]
    end else if (periph.spiActive && !dir_r[7]) begin
      drv.o[7] = periph.spiDataOut; // [RULE15]
    end
    // oscillator owns pins 0/1 outright, digital drivers off
    if (periph.osc1En) begin
      drv.oe[1:0] = 2'h0; // [RULE3]
      drv.o[1:0]  = 2'h0;
    end
  end

  // registered pin drive and peripheral inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinOut <= 8'h00;
      pinOe  <= 8'h00;
    end else begin
      pinOut <= drv.o;
      pinOe  <= drv.oe;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      extCounterIn      <= 1'b0;
      capcomp2CaptureIn <= 1'b0;
      capcomp1CaptureIn <= 1'b0;
    end else begin
      extCounterIn      <= !periph.osc1En && dir_r[0] && pinSync[0]; // [RULE17]
      capcomp2CaptureIn <= capcomp2Here && !periph.osc1En && dir_r[1] && pinSync[1]; // [RULE4]
      capcomp1CaptureIn <= dir_r[2] && pinSync[2]; // [RULE7]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usbDmIn     <= 1'b0;
      usbDpIn     <= 1'b0;
      xcvrMinusRx <= 1'b0;
      xcvrPlusRx  <= 1'b0;
    end else begin
      usbDmIn     <= usbOnNow && !extXcvr && pinSync[4]; // [RULE10]
      usbDpIn     <= usbOnNow && !extXcvr && pinSync[5]; // [RULE10]
      xcvrMinusRx <= usbOnNow && extXcvr && pinSync[4]; // [RULE11]
      xcvrPlusRx  <= usbOnNow && extXcvr && pinSync[5]; // [RULE11]
    end
  end

  // serRxIn resets high, then follows pin 7 in every mode; serClkIn resets low and reads 0 outside sync slave
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serRxIn  <= 1'b1;
      serClkIn <= 1'b0;
    end else begin
      serRxIn  <= pinSync[7]; // [RULE14]
      serClkIn <= periph.serMode == PCM_SER_SYNC && !periph.serClkMaster && pinSync[6]; // [RULE13]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      capcomp2RouteSel <= 1'b1;
      slowOscAnalogEn  <= 1'b0;
      usbOn            <= 1'b0;
      xcvrExternal     <= 1'b0;
    end else begin
      capcomp2RouteSel <= capcomp2Here; // [RULE5]
      slowOscAnalogEn  <= periph.osc1En; // [RULE3]
      usbOn            <= usbOnNow;
      xcvrExternal     <= extXcvr;
    end
  end

endmodule : pcm_port_c

// ==== verilog/pcm_regs.sv ====
// software register file: latch, direction, usb control and routing config
`timescale 1ns/1ps
module pcm_regs
  import pcm_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire pcm_bus_req_s req,
  input  wire logic [7:0]   pinLevel,
  output logic      [7:0]   latch_r,
  output logic      [7:0]   dir_r,
  output logic      [7:0]   usbCtl_r,
  output logic      [7:0]   pcfg_r,
  output logic      [7:0]   rdData_r
);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_r <= LATCH_RESET;
    end else if (req.wr && (req.addr == REG_OUT_LATCH || req.addr == REG_PIN_LEVEL)) begin
      latch_r <= req.wdata & LATCH_MASK; // [RULE16]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_r <= DIR_RESET;
    end else if (req.wr && req.addr == REG_DIRECTION) begin
      dir_r <= req.wdata & LATCH_MASK; // [RULE16]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usbCtl_r <= USBCTL_RESET;
      pcfg_r <= PCFG_RESET;
    end else if (req.wr) begin
      if (req.addr == REG_USB_CONTROL) begin
        usbCtl_r <= req.wdata & USBCTL_MASK;
      end
      if (req.addr == REG_PERIPH_CFG) begin
        pcfg_r <= {5'h00, req.wdata[2:0]};
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        REG_PIN_LEVEL:   rdData_r <= pinLevel & PIN_MASK; // [RULE16]
        REG_OUT_LATCH:   rdData_r <= latch_r; // [RULE2]
        REG_DIRECTION:   rdData_r <= dir_r; // [RULE18]
        REG_USB_CONTROL: rdData_r <= usbCtl_r;
        REG_PERIPH_CFG:  rdData_r <= pcfg_r;
        default:         rdData_r <= 8'h00;
      endcase
    end else begin
      rdData_r <= 8'h00;
    end
  end

endmodule : pcm_regs

// ==== verilog/pcm_sync.sv ====
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module pcm_sync
  import pcm_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : pcm_sync
